/* File: inc/scsi_irq_pkg.sv */
// constants and helpers for the scsi select/status interrupt block
package scsi_irq_pkg;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_SEL_ID     = 8'h41;
   localparam logic [7:0] ADDR_SEL_ID_ALT = 8'h61;
   localparam logic [7:0] ADDR_STAT1      = 8'h46;
   localparam logic [7:0] ADDR_STAT1_ALT  = 8'h66;
   localparam logic [7:0] ADDR_EN1        = 8'h47;
   localparam logic [7:0] ADDR_EN1_ALT    = 8'h67;
   localparam logic [7:0] ADDR_STAT2      = 8'h48;
   localparam logic [7:0] ADDR_EN2        = 8'h49;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ST1_SCSI_RST = 0;
   localparam int ST1_ATN      = 1;
   localparam int ST1_OFFSET   = 2;
   localparam int ST1_BUS_FREE = 3;
   localparam int ST1_BUF_PAR  = 4;
   localparam int ST1_BUS_PAR  = 5;
   localparam int ST2_SEL      = 0;
   localparam int ST2_RESEL    = 1;
   localparam int ST2_ARB_WON  = 2;
   localparam int ST2_AUTO_DONE = 3;
   localparam int ST2_XFER_DONE = 4;
   localparam int ST2_HALTED   = 5;
   localparam int ST2_MISMATCH = 6;
   localparam int ST2_REQ_ON   = 7;
   localparam logic [3:0] MAX_SEL_IDS   = 4'h2;
   localparam logic [3:0] RESEL_IDS     = 4'h2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] EN1_RST  = 6'h00;
   localparam logic [5:0] ST1_RST  = 6'h00;
   localparam logic [7:0] EN2_RST  = 8'h00;
   localparam logic [7:0] ST2_RST  = 8'h00;
   localparam logic [7:0] ID_RST   = 8'h00;
   localparam logic [7:0] RD_RST   = 8'h00;

   // ----------------------------------------------------------------
   // busy drive states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      BSY_IDLE   = 3'b001,
      BSY_TARGET = 3'b010,
      BSY_RESEL  = 3'b100
   } bsy_state_t;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [3:0] id_count(input logic [7:0] d);
      logic [3:0] n;
      n = 4'h0;
      for (int k = 0; k < 8; k++)
      begin
         n = n + {3'h0, d[k]};
      end
      return n;
   endfunction

   function automatic logic odd_ok(input logic [7:0] d, input logic p);
      return ^{d, p};
   endfunction
endpackage

/* File: hw/sel_detect.sv */
// selection and reselection recognizer with id byte capture
`timescale 1ns/1ps
`default_nettype none
module sel_detect
(
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   // bus lines, active low
   input  wire logic       i_sel_n,
   input  wire logic       i_bsy_n,
   input  wire logic       i_io_n,
   input  wire logic       i_scsi_rst_n,
   input  wire logic [7:0] i_db_n,
   input  wire logic       i_dbp_n,
   // configuration
   input  wire logic       i_auto_sel_en,
   input  wire logic       i_parity_chk_en,
   input  wire logic [2:0] i_own_id,
   // results
   output logic            o_sel_hit,
   output logic            o_resel_hit,
   output logic [7:0]      o_id_byte
);
   logic [7:0] data;
   logic       common;
   logic       sel_cond;
   logic       resel_cond;
   logic       sel_prev_r;
   logic       sel_prev_nxt;
   logic       resel_prev_r;
   logic       resel_prev_nxt;
   logic       sel_hit_nxt;
   logic       resel_hit_nxt;
   logic [7:0] id_nxt;

   // ----------------------------------------------------------------
   // condition decode
   // ----------------------------------------------------------------
   always_comb
   begin
      data = ~i_db_n;
      common = i_auto_sel_en && !i_sel_n && i_bsy_n && i_scsi_rst_n
               && data[i_own_id]
               && (!i_parity_chk_en || scsi_irq_pkg::odd_ok(data, !i_dbp_n));
      sel_cond   = common && i_io_n
                   && (scsi_irq_pkg::id_count(data) <= scsi_irq_pkg::MAX_SEL_IDS);
      resel_cond = common && !i_io_n
                   && (scsi_irq_pkg::id_count(data) == scsi_irq_pkg::RESEL_IDS);
      sel_prev_nxt   = sel_cond;
      resel_prev_nxt = resel_cond;
      sel_hit_nxt    = sel_cond && !sel_prev_r;
      resel_hit_nxt  = resel_cond && !resel_prev_r;
      id_nxt = (sel_hit_nxt || resel_hit_nxt) ? data : o_id_byte;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sel_prev_r   <= 1'b0;
         resel_prev_r <= 1'b0;
         o_sel_hit    <= 1'b0;
         o_resel_hit  <= 1'b0;
         o_id_byte    <= scsi_irq_pkg::ID_RST;
      end
      else if (i_ce)
      begin
         sel_prev_r   <= sel_prev_nxt;
         resel_prev_r <= resel_prev_nxt;
         o_sel_hit    <= sel_hit_nxt;
         o_resel_hit  <= resel_hit_nxt;
         o_id_byte    <= id_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: hw/scsi_select_status_interrupts.sv */
// scsi event status registers, interrupt enables and selection response
// Functional notes
// - enable register one clears on chip reset or host/buffer reset
// - enabled status-one flag drives host interrupt low
// - status two clears on bus reset, chip reset or host/buffer reset
// - software clears status-two flags by writing ones
// - selection needs sel low, bsy high, io high, own id, at most two ids
// - selection sets flag, target enable, drives busy, latches id byte
// - reselection like selection but io low and exactly two ids
// - reselection sets flag, busy until sel high, initiator enable, latches id
// - arbitration won sets flag, then auto continues per mode bit
// - automatic selection phase finished sets flag three
// - end of transfer sets flag four
// - halt request, or initiator phase mismatch while a transfer is active, sets flag five
// - initiator phase lines differing from expected phase set flag six
// - request low while initiator enabled sets flag seven
// - status-one flags zero to five are sticky, cleared by writing one
// - after arbitration won, mode one selects, mode zero reselects
// - enable register two gates status-two flags onto host interrupt
`timescale 1ns/1ps
`default_nettype none
module scsi_select_status_interrupts
(
   // clock, reset, enable
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic       i_ce,
   input  wire logic       i_host_buf_reset,
   // register port
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_wdata,
   output logic [7:0]      o_reg_rdata,
   // bus lines, active low
   input  wire logic       i_sel_n,
   input  wire logic       i_bsy_n,
   input  wire logic       i_io_n,
   input  wire logic       i_cd_n,
   input  wire logic       i_msg_n,
   input  wire logic       i_req_n,
   input  wire logic       i_atn_n,
   input  wire logic       i_scsi_rst_n,
   input  wire logic [7:0] i_db_n,
   input  wire logic       i_dbp_n,
   output logic            o_bsy_n_out,
   output logic            o_bsy_oe,
   // control inputs
   input  wire logic       i_auto_sel_en,
   input  wire logic       i_auto_sel_mode,
   input  wire logic       i_parity_chk_en,
   input  wire logic [2:0] i_own_id,
   input  wire logic       i_initiator_en,
   input  wire logic [2:0] i_expected_phase,
   input  wire logic       i_xfer_active,
   input  wire logic       i_bsy_release,
   // event inputs, one-cycle pulses
   input  wire logic       i_arb_won,
   input  wire logic       i_auto_phase_done,
   input  wire logic       i_xfer_done,
   input  wire logic       i_dma_halt,
   input  wire logic       i_offset_err,
   input  wire logic       i_bus_free,
   input  wire logic       i_buf_par_err,
   input  wire logic       i_bus_par_err,
   // outputs
   output logic            o_host_interrupt_n,
   output logic            o_set_target_en,
   output logic            o_set_initiator_en,
   output logic            o_start_sel,
   output logic            o_start_resel,
   output logic [7:0]      o_sel_id
);
   logic       sel_hit;
   logic       resel_hit;
   logic [5:0] en1_r;
   logic [5:0] en1_nxt;
   logic [7:0] en2_r;
   logic [7:0] en2_nxt;
   logic [5:0] st1_r;
   logic [5:0] st1_nxt;
   logic [7:0] st2_r;
   logic [7:0] st2_nxt;
   logic [5:0] st1_set;
   logic [7:0] st2_set;
   logic       wr_st1;
   logic       wr_st2;
   logic       mismatch;
   logic [7:0] rdata_nxt;
   logic       int_n_nxt;
   scsi_irq_pkg::bsy_state_t bsy_r;
   scsi_irq_pkg::bsy_state_t bsy_nxt;

   // ----------------------------------------------------------------
   // selection recognizer
   // ----------------------------------------------------------------
   sel_detect u_sel_detect
   (
      .i_ref_clk       (i_ref_clk),
      .i_rst           (i_rst),
      .i_ce            (i_ce),
      .i_sel_n         (i_sel_n),
      .i_bsy_n         (i_bsy_n),
      .i_io_n          (i_io_n),
      .i_scsi_rst_n    (i_scsi_rst_n),
      .i_db_n          (i_db_n),
      .i_dbp_n         (i_dbp_n),
      .i_auto_sel_en   (i_auto_sel_en),
      .i_parity_chk_en (i_parity_chk_en),
      .i_own_id        (i_own_id),
      .o_sel_hit       (sel_hit),
      .o_resel_hit     (resel_hit),
      .o_id_byte       (o_sel_id)
   );

   // ----------------------------------------------------------------
   // status and enable registers
   // ----------------------------------------------------------------
   always_comb
   begin
      wr_st1 = i_reg_wr && (i_reg_addr == scsi_irq_pkg::ADDR_STAT1
                            || i_reg_addr == scsi_irq_pkg::ADDR_STAT1_ALT);
      wr_st2 = i_reg_wr && (i_reg_addr == scsi_irq_pkg::ADDR_STAT2);
      mismatch = i_initiator_en
                 && (~{i_cd_n, i_io_n, i_msg_n} != i_expected_phase);
      st1_set = '0;
      st1_set[scsi_irq_pkg::ST1_SCSI_RST] = !i_scsi_rst_n;
      st1_set[scsi_irq_pkg::ST1_ATN]      = !i_atn_n;
      st1_set[scsi_irq_pkg::ST1_OFFSET]   = i_offset_err;
      st1_set[scsi_irq_pkg::ST1_BUS_FREE] = i_bus_free;
      st1_set[scsi_irq_pkg::ST1_BUF_PAR]  = i_buf_par_err;
      st1_set[scsi_irq_pkg::ST1_BUS_PAR]  = i_bus_par_err;
      st2_set = '0;
      st2_set[scsi_irq_pkg::ST2_SEL]       = sel_hit;
      st2_set[scsi_irq_pkg::ST2_RESEL]     = resel_hit;
      st2_set[scsi_irq_pkg::ST2_ARB_WON]   = i_arb_won;
      st2_set[scsi_irq_pkg::ST2_AUTO_DONE] = i_auto_phase_done;
      st2_set[scsi_irq_pkg::ST2_XFER_DONE] = i_xfer_done;
      st2_set[scsi_irq_pkg::ST2_HALTED]    = i_dma_halt
                                             || (mismatch && i_xfer_active);
      st2_set[scsi_irq_pkg::ST2_MISMATCH]  = mismatch;
      st2_set[scsi_irq_pkg::ST2_REQ_ON]    = !i_req_n && i_initiator_en;
      // set after clear so a same-cycle event survives
      st1_nxt = (st1_r & ~(wr_st1 ? i_reg_wdata[5:0] : 6'h00)) | st1_set;
      st2_nxt = (st2_r & ~(wr_st2 ? i_reg_wdata : 8'h00)) | st2_set;
      en1_nxt = (i_reg_wr && (i_reg_addr == scsi_irq_pkg::ADDR_EN1
                 || i_reg_addr == scsi_irq_pkg::ADDR_EN1_ALT)) ? i_reg_wdata[5:0] : en1_r;
      en2_nxt = (i_reg_wr && i_reg_addr == scsi_irq_pkg::ADDR_EN2) ? i_reg_wdata : en2_r;
      if (!i_scsi_rst_n)
      begin
         // bus reset marks bit zero and drops the other bus flags
         st1_nxt = 6'h01;
         st2_nxt = scsi_irq_pkg::ST2_RST;
      end
      if (i_host_buf_reset)
      begin
         st1_nxt = scsi_irq_pkg::ST1_RST;
         st2_nxt = scsi_irq_pkg::ST2_RST;
         en1_nxt = scsi_irq_pkg::EN1_RST;
         en2_nxt = scsi_irq_pkg::EN2_RST;
      end
      // registered so the pin comes from a flop; one cycle behind the flags
      int_n_nxt = !(|(st1_r & en1_r) || |(st2_r & en2_r));
   end

   // ----------------------------------------------------------------
   // busy drive and sequencing pulses
   // ----------------------------------------------------------------
   always_comb
   begin
      bsy_nxt = bsy_r;
      case (bsy_r)
         scsi_irq_pkg::BSY_IDLE:
         begin
            if (sel_hit)
               bsy_nxt = scsi_irq_pkg::BSY_TARGET;
            else if (resel_hit)
               bsy_nxt = scsi_irq_pkg::BSY_RESEL;
         end
         scsi_irq_pkg::BSY_TARGET:
         begin
            if (i_bsy_release)
               bsy_nxt = scsi_irq_pkg::BSY_IDLE;
         end
         scsi_irq_pkg::BSY_RESEL:
         begin
            if (i_sel_n)
               bsy_nxt = scsi_irq_pkg::BSY_IDLE;
         end
         default:
            bsy_nxt = scsi_irq_pkg::BSY_IDLE;
      endcase
      if (!i_scsi_rst_n || i_host_buf_reset)
         bsy_nxt = scsi_irq_pkg::BSY_IDLE;
      case (i_reg_addr)
         scsi_irq_pkg::ADDR_STAT1, scsi_irq_pkg::ADDR_STAT1_ALT:
            rdata_nxt = {!i_scsi_rst_n, scsi_irq_pkg::odd_ok(~i_db_n, !i_dbp_n), st1_r};
         scsi_irq_pkg::ADDR_EN1, scsi_irq_pkg::ADDR_EN1_ALT:
            rdata_nxt = {2'h0, en1_r};
         scsi_irq_pkg::ADDR_STAT2:
            rdata_nxt = st2_r;
         scsi_irq_pkg::ADDR_EN2:
            rdata_nxt = en2_r;
         scsi_irq_pkg::ADDR_SEL_ID, scsi_irq_pkg::ADDR_SEL_ID_ALT:
            rdata_nxt = o_sel_id;
         default:
            rdata_nxt = 8'h00;
      endcase
      if (!i_reg_rd)
         rdata_nxt = o_reg_rdata;
   end

   always_ff @(posedge i_ref_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         en1_r              <= scsi_irq_pkg::EN1_RST;
         en2_r              <= scsi_irq_pkg::EN2_RST;
         st1_r              <= scsi_irq_pkg::ST1_RST;
         st2_r              <= scsi_irq_pkg::ST2_RST;
         bsy_r              <= scsi_irq_pkg::BSY_IDLE;
         o_bsy_n_out        <= 1'b1;
         o_bsy_oe           <= 1'b0;
         o_host_interrupt_n <= 1'b1;
         o_set_target_en    <= 1'b0;
         o_set_initiator_en <= 1'b0;
         o_start_sel        <= 1'b0;
         o_start_resel      <= 1'b0;
         o_reg_rdata        <= scsi_irq_pkg::RD_RST;
      end
      else if (i_ce)
      begin
         en1_r              <= en1_nxt;
         en2_r              <= en2_nxt;
         st1_r              <= st1_nxt;
         st2_r              <= st2_nxt;
         bsy_r              <= bsy_nxt;
         o_bsy_n_out        <= bsy_nxt == scsi_irq_pkg::BSY_IDLE;
         o_bsy_oe           <= bsy_nxt != scsi_irq_pkg::BSY_IDLE;
         o_host_interrupt_n <= int_n_nxt;
         o_set_target_en    <= sel_hit;
         o_set_initiator_en <= resel_hit;
         o_start_sel        <= i_arb_won && i_auto_sel_en && i_auto_sel_mode;
         o_start_resel      <= i_arb_won && i_auto_sel_en && !i_auto_sel_mode;
         o_reg_rdata        <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_sel_taken;
      i_ce && sel_hit && i_scsi_rst_n && !i_host_buf_reset
      && (bsy_r == scsi_irq_pkg::BSY_IDLE);
   endsequence
   sequence s_sel_answered;
      st2_r[scsi_irq_pkg::ST2_SEL] && o_bsy_oe && o_set_target_en;
   endsequence

   property p_int_st1;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && |(st1_r & en1_r)) |=> !o_host_interrupt_n;
   endproperty
   a_int_st1: assert property (p_int_st1) else $error("status one irq not raised");

   property p_int_st2;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && |(st2_r & en2_r)) |=> !o_host_interrupt_n;
   endproperty
   a_int_st2: assert property (p_int_st2) else $error("status two irq not raised");

   property p_int_idle;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !(|(st1_r & en1_r)) && !(|(st2_r & en2_r))) |=> o_host_interrupt_n;
   endproperty
   a_int_idle: assert property (p_int_idle) else $error("irq low with nothing enabled");

   property p_en1_clear;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && i_host_buf_reset) |=> (en1_r == scsi_irq_pkg::EN1_RST);
   endproperty
   a_en1_clear: assert property (p_en1_clear) else $error("enable one not cleared");

   property p_st2_busrst;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !i_scsi_rst_n) |=> (st2_r == scsi_irq_pkg::ST2_RST);
   endproperty
   a_st2_busrst: assert property (p_st2_busrst)
      else $error("status two kept on bus reset");

   property p_w1c;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && wr_st2 && st2_set == 8'h00) |=> ((st2_r & $past(i_reg_wdata)) == 8'h00);
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear");

   property p_set_wins;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !i_host_buf_reset && i_scsi_rst_n && st2_set[scsi_irq_pkg::ST2_ARB_WON])
      |=> st2_r[scsi_irq_pkg::ST2_ARB_WON];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

   property p_sel_resp;
      @(posedge i_ref_clk) disable iff (i_rst)
      s_sel_taken |=> s_sel_answered;
   endproperty
   a_sel_resp: assert property (p_sel_resp) else $error("selection response missing");

   property p_resel_hold;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && bsy_r == scsi_irq_pkg::BSY_RESEL && !i_sel_n && i_scsi_rst_n
       && !i_host_buf_reset) |=> o_bsy_oe;
   endproperty
   a_resel_hold: assert property (p_resel_hold)
      else $error("busy dropped before sel high");

   property p_auto_mode;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && i_arb_won && i_auto_sel_en) |=> (o_start_sel != o_start_resel);
   endproperty
   a_auto_mode: assert property (p_auto_mode)
      else $error("no continuation after arb won");

   property p_req_on;
      @(posedge i_ref_clk) disable iff (i_rst)
      (i_ce && !i_req_n && i_initiator_en && i_scsi_rst_n && !i_host_buf_reset)
      |=> st2_r[scsi_irq_pkg::ST2_REQ_ON];
   endproperty
   a_req_on: assert property (p_req_on) else $error("request seen flag not set");
endmodule
`default_nettype wire

/* File: test/scsi_far_end.sv */
// far-end initiator or target model driving selection onto the bus
`timescale 1ns/1ps
`default_nettype none
module scsi_far_end
(
   // commands from the bench
   input  wire logic       i_go,
   input  wire logic       i_resel,
   input  wire logic       i_bad_par,
   input  wire logic [7:0] i_ids,
   // bus lines, active low
   output logic            o_sel_n,
   output logic            o_io_n,
   output logic [7:0]      o_db_n,
   output logic            o_dbp_n
);
   // released lines float high through the terminators
   always_comb
   begin
      o_sel_n = ~i_go;
      o_io_n  = ~(i_go & i_resel);
      o_db_n  = i_go ? ~i_ids : 8'hff;
      o_dbp_n = i_go ? ~((~^i_ids) ^ i_bad_par) : 1'b1;
   end
endmodule
`default_nettype wire

/* File: test/scsi_select_status_interrupts_test.sv */
// self-checking bench for the select/status interrupt block
`timescale 1ns/1ps
`default_nettype none
module scsi_select_status_interrupts_test;
   typedef struct packed {logic [7:0] ev; logic [7:0] sa; logic [7:0] ea; logic [7:0] bits;} row_t;
   logic       i_ref_clk, i_rst, i_host_buf_reset, i_reg_wr, i_reg_rd, ce;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, i_db_n, o_sel_id, ev, ids, msk;
   logic       i_sel_n, i_bsy_n, i_io_n, i_cd_n, i_msg_n, i_req_n, i_atn_n, i_scsi_rst_n;
   logic       i_dbp_n, o_bsy_n_out, o_bsy_oe, i_auto_sel_en, i_auto_sel_mode, i_parity_chk_en;
   logic       i_initiator_en, i_xfer_active, i_bsy_release, o_host_interrupt_n;
   logic       o_set_target_en, o_set_initiator_en, o_start_sel, o_start_resel, go, resel, bad;
   logic [2:0] i_own_id, i_expected_phase;
   int         fail_count = 0;
   int         cmp_count = 0;
   row_t       rows [8] = '{'{8'h01, 8'h48, 8'h49, 8'h04}, '{8'h02, 8'h48, 8'h49, 8'h08},
                            '{8'h04, 8'h48, 8'h49, 8'h10}, '{8'h08, 8'h48, 8'h49, 8'h20},
                            '{8'h10, 8'h46, 8'h47, 8'h04}, '{8'h20, 8'h46, 8'h47, 8'h08},
                            '{8'h40, 8'h46, 8'h47, 8'h10}, '{8'h80, 8'h46, 8'h47, 8'h20}};

   // busy line with terminator pull-up
   assign i_bsy_n = ~(o_bsy_oe & ~o_bsy_n_out);

   scsi_far_end far (.i_go(go), .i_resel(resel), .i_bad_par(bad), .i_ids(ids),
      .o_sel_n(i_sel_n), .o_io_n(i_io_n), .o_db_n(i_db_n), .o_dbp_n(i_dbp_n));

   scsi_select_status_interrupts uut (.i_ref_clk, .i_rst, .i_ce(ce), .i_host_buf_reset,
      .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .i_sel_n, .i_bsy_n,
      .i_io_n, .i_cd_n, .i_msg_n, .i_req_n, .i_atn_n, .i_scsi_rst_n, .i_db_n, .i_dbp_n,
      .o_bsy_n_out, .o_bsy_oe, .i_auto_sel_en, .i_auto_sel_mode, .i_parity_chk_en, .i_own_id,
      .i_initiator_en, .i_expected_phase, .i_xfer_active, .i_bsy_release,
      .i_arb_won(ev[0]), .i_auto_phase_done(ev[1]), .i_xfer_done(ev[2]), .i_dma_halt(ev[3]),
      .i_offset_err(ev[4]), .i_bus_free(ev[5]), .i_buf_par_err(ev[6]), .i_bus_par_err(ev[7]),
      .o_host_interrupt_n, .o_set_target_en, .o_set_initiator_en, .o_start_sel,
      .o_start_resel, .o_sel_id);

   initial
   begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %0t byte got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      cmp_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("ERROR %0t bit got %b exp %b", $time, g, e);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      tick(1);
      i_reg_wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      tick(1);
      i_reg_rd = 1'b0;
      tick(1);
      chk8(o_reg_rdata & m, e);
   endtask

   task automatic pulse(input logic [7:0] v);
      ev = v;
      tick(1);
      ev = 8'h00;
   endtask

   // bounded wait for any response pulse, then compare all four
   task automatic wait_resp(input logic [3:0] e);
      int k;
      k = 0;
      while (!(o_set_target_en | o_set_initiator_en | o_start_sel | o_start_resel) && k < 6)
      begin
         tick(1);
         k++;
      end
      chk8({4'h0, o_set_target_en, o_set_initiator_en, o_start_sel, o_start_resel}, {4'h0, e});
   endtask

   initial
   begin
      repeat (4000) @(negedge i_ref_clk);
      fail_count++;
      print_verdict();
   end

   initial
   begin
      {i_rst, i_cd_n, i_msg_n, i_req_n, i_atn_n, i_scsi_rst_n} = 6'h3f;
      {i_host_buf_reset, i_reg_wr, i_reg_rd, i_auto_sel_en, i_auto_sel_mode} = 5'h00;
      ce = 1'b1;
      {i_parity_chk_en, i_initiator_en, i_xfer_active, i_bsy_release, go, resel, bad} = 7'h00;
      {i_reg_addr, i_reg_wdata, ev, ids} = 32'h0;
      i_own_id = 3'h3;
      i_expected_phase = 3'h0;
      tick(8);
      i_rst = 1'b0;
      chk1(o_host_interrupt_n, 1'b1);
      chk1(o_bsy_oe, 1'b0);
      rd_chk(8'h67, 8'hff, 8'h00);
      rd_chk(8'h48, 8'hff, 8'h00);
      rd_chk(8'h4a, 8'hff, 8'h00);
      reg_wr(8'h47, 8'hff);
      rd_chk(8'h47, 8'hff, 8'h3f);
      reg_wr(8'h67, 8'h00);
      foreach (rows[i])
      begin
         msk = rows[i].sa[1] ? 8'h3f : 8'hff;
         pulse(rows[i].ev);
         rd_chk(rows[i].sa, msk, rows[i].bits);
         chk1(o_host_interrupt_n, 1'b1);
         reg_wr(rows[i].ea, rows[i].bits);
         tick(2);
         chk1(o_host_interrupt_n, 1'b0);
         reg_wr(rows[i].sa, 8'h00);
         rd_chk(rows[i].sa, msk, rows[i].bits);
         reg_wr(rows[i].sa, rows[i].bits);
         tick(2);
         chk1(o_host_interrupt_n, 1'b1);
         rd_chk(rows[i].sa, msk, 8'h00);
         reg_wr(rows[i].ea, 8'h00);
      end
      // host/buffer reset and bus reset
      reg_wr(8'h47, 8'h3f);
      pulse(8'h21);
      i_host_buf_reset = 1'b1;
      tick(1);
      i_host_buf_reset = 1'b0;
      rd_chk(8'h47, 8'hff, 8'h00);
      rd_chk(8'h48, 8'hff, 8'h00);
      rd_chk(8'h46, 8'h3f, 8'h00);
      pulse(8'h21);
      i_scsi_rst_n = 1'b0;
      tick(1);
      i_scsi_rst_n = 1'b1;
      rd_chk(8'h48, 8'hff, 8'h00);
      rd_chk(8'h46, 8'h3f, 8'h01);
      reg_wr(8'h46, 8'h3f);
      // selection as target, held until released
      i_auto_sel_en = 1'b1;
      ids = 8'h09;
      go = 1'b1;
      wait_resp(4'b1000);
      chk8(o_sel_id, 8'h09);
      go = 1'b0;
      tick(3);
      chk1(i_bsy_n, 1'b0);
      rd_chk(8'h61, 8'hff, 8'h09);
      rd_chk(8'h48, 8'hff, 8'h01);
      i_bsy_release = 1'b1;
      tick(1);
      i_bsy_release = 1'b0;
      tick(2);
      chk1(o_bsy_oe, 1'b0);
      reg_wr(8'h48, 8'hff);
      // refused: bad parity, three ids, automatic response off
      for (int k = 0; k < 3; k++)
      begin
         i_parity_chk_en = (k == 0);
         bad = (k == 0);
         ids = (k == 1) ? 8'h0b : 8'h09;
         i_auto_sel_en = (k != 2);
         go = 1'b1;
         tick(6);
         chk1(o_bsy_oe, 1'b0);
         go = 1'b0;
         rd_chk(8'h48, 8'hff, 8'h00);
      end
      // reselection, busy until select goes high
      {i_parity_chk_en, bad, i_auto_sel_en, resel, go} = 5'b10111;
      ids = 8'h88;
      wait_resp(4'b0100);
      chk8(o_sel_id, 8'h88);
      tick(2);
      chk1(i_bsy_n, 1'b0);
      go = 1'b0;
      tick(2);
      chk1(o_bsy_oe, 1'b0);
      rd_chk(8'h48, 8'hff, 8'h02);
      reg_wr(8'h48, 8'hff);
      resel = 1'b0;
      // arbitration won continues per mode bit
      for (int m = 0; m < 2; m++)
      begin
         i_auto_sel_mode = m[0];
         ev = 8'h01;
         tick(1);
         ev = 8'h00;
         wait_resp(m[0] ? 4'b0010 : 4'b0001);
         reg_wr(8'h48, 8'hff);
      end
      // initiator phase mismatch and request, set beats clear
      {i_initiator_en, i_xfer_active, i_cd_n, i_req_n} = 4'b1100;
      tick(2);
      reg_wr(8'h48, 8'hc0);
      rd_chk(8'h48, 8'hff, 8'he0);
      {i_initiator_en, i_xfer_active} = 2'b00;
      tick(1);
      reg_wr(8'h48, 8'hff);
      rd_chk(8'h48, 8'hff, 8'h00);
      // low clock enable freezes every flag
      ce = 1'b0;
      pulse(8'h04);
      ce = 1'b1;
      rd_chk(8'h48, 8'hff, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
